// file: design/watchdog_and_reset_control.sv
`timescale 1ns/10ps
module watchdog_and_reset_control #(
  parameter int unsigned TICK_CYCLES = wdt_pkg::TICK_CYCLES_DEFAULT
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire wdt_pkg::wdt_cmd_t cmd,
  input wire logic button_n,
  input wire logic backplane_reset_in_n,
  input wire wdt_pkg::supply_t supply,
  output logic timeout_interrupt_request,
  output logic nmi,
  output logic periph_reset_n,
  output logic pci_reset_n,
  output logic wdt_running
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NPIN = 8;
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins;
  logic btn_n_s;
  logic bp_n_s;
  wdt_pkg::supply_t sup_s;

  assign pins_raw = {button_n, backplane_reset_in_n, supply};

  // pins idle in their inactive state after reset
  sync2 #(
    .W(NPIN),
    .INIT(8'hC7)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(pins_raw),
    .q(pins)
  );

  assign btn_n_s = pins[7];
  assign bp_n_s = pins[6];
  assign sup_s = pins[5:0];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic enabled;
    wdt_pkg::action_t action;
    logic [wdt_pkg::STEP_W-1:0] step;
    logic [wdt_pkg::PRESC_W-1:0] presc;
    logic [wdt_pkg::TICK_W-1:0] ticks;
    logic irq;
    logic nmi;
    logic bite;
    logic [wdt_pkg::HOLD_W-1:0] hold;
    logic rst_out;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic tick;
  logic expire;
  logic [wdt_pkg::TICK_W-1:0] limit;
  logic any_src;

  assign tick = cur.presc == wdt_pkg::PRESC_W'(TICK_CYCLES - 1);
  assign limit = wdt_pkg::TICK_W'((1 << cur.step) - 1);
  assign expire = cur.enabled && tick && cur.ticks == limit;

  // the bite latches so a one-cycle expiry still gives a full reset
  assign any_src = cur.bite || !btn_n_s || !bp_n_s
    || sup_s.pwr5_low || sup_s.pwr33_low || sup_s.conv_fail
    || !sup_s.pg5 || !sup_s.pg33 || !sup_s.pgcore;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.irq = 1'b0;
    next_cur.nmi = 1'b0;
    // a disable request is simply not looked at once running
    if (!cur.enabled)
    begin
      // config only accepted while stopped; enable locks it
      next_cur.action = cmd.action;
      next_cur.step = (cmd.step < 4'(wdt_pkg::NUM_STEPS)) ? cmd.step
        : 4'(wdt_pkg::NUM_STEPS - 1);
      next_cur.enabled = cmd.enable;
      next_cur.presc = '0;
      next_cur.ticks = '0;
    end
    else if (cmd.retrigger || expire)
    begin
      next_cur.presc = '0;
      next_cur.ticks = '0;
    end
    else
    begin
      next_cur.presc = tick ? '0 : cur.presc + 1'b1;
      next_cur.ticks = tick ? cur.ticks + 1'b1 : cur.ticks;
    end
    // a retrigger in the expiry cycle wins over the action
    if (expire && !cmd.retrigger)
    begin
      unique case (cur.action)
        wdt_pkg::ACT_IRQ: next_cur.irq = 1'b1;
        wdt_pkg::ACT_NMI: next_cur.nmi = 1'b1;
        default: next_cur.bite = 1'b1;
      endcase
    end
    if (cur.bite)
    begin
      next_cur.hold = cur.hold + 1'b1;
      if (cur.hold == 5'(wdt_pkg::RESET_HOLD_CYCLES - 1))
      begin
        next_cur.bite = 1'b0;
        next_cur.hold = '0;
      end
    end
    next_cur.rst_out = any_src;
    if (cur.rst_out)
    begin
      // board reset returns the watchdog to its stopped state
      next_cur.enabled = 1'b0;
      next_cur.presc = '0;
      next_cur.ticks = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur <= '{enabled: 1'b0, action: wdt_pkg::ACTION_RESET,
        step: wdt_pkg::STEP_RESET, presc: '0, ticks: '0, irq: 1'b0,
        nmi: 1'b0, bite: 1'b0, hold: '0, rst_out: 1'b1};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign timeout_interrupt_request = cur.irq;
  assign nmi = cur.nmi;
  assign periph_reset_n = !cur.rst_out;
  assign pci_reset_n = !cur.rst_out;
  assign wdt_running = cur.enabled;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_action_irq;
    @(posedge clk) disable iff (!rstn)
    expire && !cmd.retrigger && cur.action == wdt_pkg::ACT_IRQ
      |=> timeout_interrupt_request && !nmi;
  endproperty
  a_action_irq: assert property (p_action_irq)
    else $error("irq action not raised on expiry");

  property p_action_nmi;
    @(posedge clk) disable iff (!rstn)
    expire && !cmd.retrigger && cur.action == wdt_pkg::ACT_NMI
      |=> nmi && !timeout_interrupt_request;
  endproperty
  a_action_nmi: assert property (p_action_nmi)
    else $error("nmi action not raised on expiry");

  property p_step_range;
    @(posedge clk) disable iff (!rstn)
    cur.step < 4'(wdt_pkg::NUM_STEPS);
  endproperty
  a_step_range: assert property (p_step_range)
    else $error("timeout step out of range");

  property p_no_disable;
    @(posedge clk) disable iff (!rstn)
    cur.enabled && !cur.rst_out |=> cur.enabled;
  endproperty
  a_no_disable: assert property (p_no_disable)
    else $error("watchdog stopped while running");

  property p_button;
    @(posedge clk) disable iff (!rstn)
    !btn_n_s || !bp_n_s |=> !pci_reset_n;
  endproperty
  a_button: assert property (p_button)
    else $error("button or backplane reset not forwarded");

  property p_supply_low;
    @(posedge clk) disable iff (!rstn)
    sup_s.pwr5_low || sup_s.pwr33_low || sup_s.conv_fail
      |=> !pci_reset_n && !periph_reset_n;
  endproperty
  a_supply_low: assert property (p_supply_low)
    else $error("supply fault did not reset");

  property p_power_good;
    @(posedge clk) disable iff (!rstn)
    !(sup_s.pg5 && sup_s.pg33 && sup_s.pgcore) |=> !periph_reset_n;
  endproperty
  a_power_good: assert property (p_power_good)
    else $error("power good loss did not reset");

  property p_bite_reset;
    @(posedge clk) disable iff (!rstn)
    expire && !cmd.retrigger && cur.action == wdt_pkg::ACT_RESET
      |=> ##1 !pci_reset_n [*8];
  endproperty
  a_bite_reset: assert property (p_bite_reset)
    else $error("watchdog bite gave no board reset");

  property p_retrigger;
    @(posedge clk) disable iff (!rstn)
    cur.enabled && cmd.retrigger && !cur.rst_out
      |=> cur.ticks == '0 && cur.presc == '0;
  endproperty
  a_retrigger: assert property (p_retrigger)
    else $error("retrigger did not restart count");

endmodule

// file: design/wdt_pkg.sv
package wdt_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BASE_TIMEOUT_MS = 125;
  localparam int unsigned MAX_TIMEOUT_S = 256;
  // one tick per shortest timeout step
  localparam int unsigned TICK_CYCLES_DEFAULT =
    (CLK_HZ / 1000) * BASE_TIMEOUT_MS;
  localparam int unsigned NUM_STEPS = 12;
  // step k lasts 2**k ticks: 125 ms .. 256 s
  localparam int unsigned STEP_W = 4;
  localparam int unsigned TICK_W = 12;
  localparam int unsigned PRESC_W = 26;
  // minimum width of the board reset pulse after a watchdog bite
  localparam int unsigned RESET_HOLD_CYCLES = 16;
  localparam int unsigned HOLD_W = 5;

  // ---------------------------------------------------------------
  // expiry action encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_IRQ = 2'h0,
    ACT_NMI = 2'h1,
    ACT_RESET = 2'h2
  } action_t;

  localparam logic [STEP_W-1:0] STEP_RESET = 4'h0;
  localparam action_t ACTION_RESET = ACT_IRQ;

  typedef struct packed {
    logic enable;
    logic retrigger;
    action_t action;
    logic [STEP_W-1:0] step;
  } wdt_cmd_t;

  typedef struct packed {
    logic pwr5_low;
    logic pwr33_low;
    logic conv_fail;
    logic pg5;
    logic pg33;
    logic pgcore;
  } supply_t;

endpackage

// file: design/sync2.sv
`timescale 1ns/10ps
module sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// file: testbench/board_power_model.sv
`timescale 1ns/10ps
// ----
// backplane and supply monitors, one fault at a time
// ----
module board_power_model (
  input wire logic clk,
  input wire logic [2:0] fault,
  output logic backplane_reset_in_n,
  output wdt_pkg::supply_t supply
);
  always_ff @(posedge clk)
  begin
    backplane_reset_in_n <= fault != 3'h1;
    supply.pwr5_low <= fault == 3'h2;
    supply.pwr33_low <= fault == 3'h3;
    supply.conv_fail <= fault == 3'h4;
    supply.pg5 <= fault != 3'h5;
    supply.pg33 <= fault != 3'h6;
    supply.pgcore <= fault != 3'h7;
  end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  // short tick keeps the 256 s step within reach
  localparam int unsigned TICK = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wdt_pkg::wdt_cmd_t cmd = '0;
  logic button_n = 1'b1;
  logic [2:0] fault = 3'h0;
  logic bp_n;
  wdt_pkg::supply_t supply;
  logic irq, nmi, periph_reset_n, pci_reset_n, running;
  int bad_count = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  board_power_model board_power_model_inst (.clk(clk), .fault(fault),
    .backplane_reset_in_n(bp_n), .supply(supply));
  watchdog_and_reset_control #(.TICK_CYCLES(TICK))
    watchdog_and_reset_control_inst (.clk(clk), .rstn(rstn), .cmd(cmd),
    .button_n(button_n), .backplane_reset_in_n(bp_n), .supply(supply),
    .timeout_interrupt_request(irq), .nmi(nmi),
    .periph_reset_n(periph_reset_n), .pci_reset_n(pci_reset_n),
    .wdt_running(running));
  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // a reset is the only way to stop a running watchdog
  task automatic start(input logic [1:0] act, input logic [3:0] step);
    @(posedge clk);
    rstn <= 1'b0;
    cmd <= '0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmd.action <= wdt_pkg::action_t'(act);
    cmd.step <= step;
    cmd.enable <= 1'b1;
  endtask
  task automatic expire(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (irq !== 1'b1 && nmi !== 1'b1 && pci_reset_n !== 1'b0 && n < 9000);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_actions();
    int n;
    for (int a = 0; a < 2; a++)
    begin
      start(a[1:0], 4'h0);
      expire(n);
      check(irq, a == 0);
      check(nmi, a == 1);
      check(pci_reset_n, 1'b1);
      @(posedge clk);
      #1;
      check(irq | nmi, 1'b0);
    end
  endtask
  // codes 2 and 3 both bite; enable drops so the bite leaves it stopped
  task automatic t_bite();
    int n;
    for (int a = 2; a < 4; a++)
    begin
      start(a[1:0], 4'h0);
      @(posedge clk);
      cmd.enable <= 1'b0;
      expire(n);
      check(periph_reset_n, 1'b0);
      check(irq | nmi, 1'b0);
      repeat (14) @(posedge clk);
      #1;
      check(pci_reset_n, 1'b0);
      repeat (12) @(posedge clk);
      #1;
      check({pci_reset_n, running}, 2'h2);
    end
  endtask
  task automatic t_kick();
    int n;
    start(2'h0, 4'h1);
    @(posedge clk);
    cmd.enable <= 1'b0;
    repeat (4)
    begin
      repeat (6)
      begin
        @(posedge clk);
        #1;
        check(irq, 1'b0);
      end
      @(posedge clk);
      cmd.retrigger <= 1'b1;
      @(posedge clk);
      cmd.retrigger <= 1'b0;
    end
    #1;
    check(running, 1'b1);
    expire(n);
    check(n >= 6 && n <= 9 && irq === 1'b1, 1'b1);
  endtask
  task automatic t_steps();
    int n, p;
    for (int k = 0; k < 4; k++)
    begin
      start(2'h0, k == 3 ? 4'hB : k[3:0]);
      expire(n);
      // one edge to take the enable, then 2**k ticks; 2044 = 2**11 - 2**2
      if (k == 0)
        check(n, TICK + 1);
      else
        check(n - p, k == 3 ? TICK * 2044 : TICK << (k - 1));
      p = n;
    end
    start(2'h0, 4'hF);
    expire(n);
    check(n, p);
  endtask
  task automatic t_sources();
    for (int s = 0; s < 8; s++)
    begin
      start(2'h0, 4'hB);
      repeat (2) @(posedge clk);
      if (s == 0)
        button_n <= 1'b0;
      else
        fault <= s[2:0];
      repeat (6) @(posedge clk);
      #1;
      check({pci_reset_n, periph_reset_n}, 2'h0);
      check(running, 1'b0);
      @(posedge clk);
      button_n <= 1'b1;
      fault <= 3'h0;
      repeat (6) @(posedge clk);
      #1;
      check(pci_reset_n, 1'b1);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_actions();
    t_bite();
    t_kick();
    t_steps();
    t_sources();
    end_of_test();
  end
  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule
